// ### logic/imu_top.sv
// Purpose: integer multiply datapath, single cycle except with a peripheral source, status flags untouched
// Assumes: operands read from register file / data memory by the core
// Notes: outputs are registered write-back requests one cycle after issue, two with a peripheral source

`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - signed by signed with pair destination writes the full product to rd and rd+1.
// - signed base by unsigned source writes the full product to the pair.
// - unsigned base by signed source writes the full product to the pair.
// - unsigned by unsigned writes the full product to rd and the register above.
// - an accumulator destination takes the product in all four signedness forms.
// - accumulator forms include signed base with unsigned source.
// - word forms write the low product word to one register only, all four forms.
// - the five-bit unsigned immediate may replace the source with an accumulator target.
// - the immediate form may write the full product to a register pair.
// - the immediate form may write one register only.
// - file form multiplies memory word by default register into w3 high and w2 low.
// - every form completes in one cycle unless its source is a peripheral register, and never touches status flags.
// - a peripheral register source adds one extra cycle.
module imu_top
   import imu_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire imu_req_s req,
   input wire logic [IMU_DW-1:0] base_operand_reg,
   input wire logic [IMU_DW-1:0] source_operand_reg,
   input wire logic [IMU_DW-1:0] file_word,
   input wire logic [IMU_DW-1:0] default_working_reg,
   output logic req_ready,
   output logic done,
   output imu_wb_s wb,
   output logic status_wr
);
   logic [IMU_DW-1:0] op_a;
   logic [IMU_DW-1:0] op_b;
   logic a_s;
   logic b_s;
   logic [IMU_PW-1:0] prod;
   logic prod_signed;
   logic [IMU_AW-1:0] acc_val;

   typedef enum logic {IMU_ST_IDLE, IMU_ST_WAIT} imu_state_e;
   imu_state_e state_ff, nxt_state;
   imu_req_s hold_ff, nxt_hold;
   logic [IMU_DW-1:0] ha_ff, nxt_ha;
   logic [IMU_DW-1:0] hb_ff, nxt_hb;
   logic done_ff, nxt_done;
   logic ready_ff, nxt_ready;
   imu_wb_s wb_ff, nxt_wb;
   imu_req_s cur;
   logic fire;

   always_comb begin
      // file form ignores operand selects and uses memory word times default reg
      cur = (state_ff == IMU_ST_WAIT) ? hold_ff : req;
      if (state_ff == IMU_ST_WAIT) begin
         op_a = ha_ff;
         op_b = hb_ff;
      end else if (req.dst == IMU_DST_FILE) begin
         op_a = file_word;
         op_b = default_working_reg;
      end else begin
         op_a = base_operand_reg;
         op_b = req.use_lit ? {{(IMU_DW-IMU_LW){1'b0}}, req.lit} : source_operand_reg;
      end
      a_s = (cur.dst == IMU_DST_FILE) ? 1'b0 : cur.base_signed;
      b_s = (cur.dst == IMU_DST_FILE || cur.use_lit) ? 1'b0 : cur.src_signed;
   end

   imu_mult_core u_core (
      .a(op_a),
      .a_signed(a_s),
      .b(op_b),
      .b_signed(b_s),
      .prod(prod),
      .prod_signed(prod_signed)
   );

   imu_acc_extend u_ext (
      .prod(prod),
      .prod_signed(prod_signed),
      .acc_val(acc_val)
   );

   // peripheral source costs one stall cycle; operands held so late reads cannot skew it
   always_comb begin
      nxt_state = state_ff;
      nxt_hold = hold_ff;
      nxt_ha = ha_ff;
      nxt_hb = hb_ff;
      nxt_ready = ready_ff;
      fire = 1'b0;
      case (state_ff)
         IMU_ST_IDLE: begin
            if (req_valid && ready_ff) begin
               if (req.periph_src) begin
                  nxt_state = IMU_ST_WAIT;
                  nxt_hold = req;
                  nxt_ha = op_a;
                  nxt_hb = op_b;
                  nxt_ready = 1'b0;
               end else begin
                  fire = 1'b1;
               end
            end
         end
         IMU_ST_WAIT: begin
            fire = 1'b1;
            nxt_state = IMU_ST_IDLE;
            nxt_ready = 1'b1;
         end
         default: begin
            nxt_state = IMU_ST_IDLE;
            nxt_ready = 1'b1;
         end
      endcase
   end

   always_comb begin
      nxt_wb = '0;
      nxt_done = fire;
      if (fire) begin
         case (cur.dst)
            IMU_DST_PAIR: begin
               nxt_wb.wr_lo = 1'b1;
               nxt_wb.wr_hi = 1'b1;
               nxt_wb.lo_reg = cur.dst_reg;
               nxt_wb.hi_reg = cur.dst_reg + IMU_REG_STEP;
               nxt_wb.lo_data = prod[IMU_DW-1:0];
               nxt_wb.hi_data = prod[IMU_PW-1:IMU_DW];
            end
            IMU_DST_WORD: begin
               nxt_wb.wr_lo = 1'b1;
               nxt_wb.lo_reg = cur.dst_reg;
               nxt_wb.lo_data = prod[IMU_DW-1:0];
            end
            IMU_DST_ACC: begin
               nxt_wb.acc_wr = 1'b1;
               nxt_wb.acc_sel = cur.acc_sel;
               nxt_wb.acc_data = acc_val;
            end
            IMU_DST_FILE: begin
               nxt_wb.wr_lo = 1'b1;
               nxt_wb.wr_hi = 1'b1;
               nxt_wb.lo_reg = IMU_PROD_LO_REG;
               nxt_wb.hi_reg = IMU_PROD_HI_REG;
               nxt_wb.lo_data = prod[IMU_DW-1:0];
               nxt_wb.hi_data = prod[IMU_PW-1:IMU_DW];
            end
            default: nxt_wb = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= IMU_ST_IDLE;
         hold_ff <= '0;
         ha_ff <= '0;
         hb_ff <= '0;
         ready_ff <= 1'b1;
         done_ff <= 1'b0;
         wb_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         hold_ff <= nxt_hold;
         ha_ff <= nxt_ha;
         hb_ff <= nxt_hb;
         ready_ff <= nxt_ready;
         done_ff <= nxt_done;
         wb_ff <= nxt_wb;
      end
   end

   always_comb begin
      req_ready = ready_ff;
      done = done_ff;
      wb = wb_ff;
   end
   // flags never written by any form
   logic status_ff;
   always_ff @(posedge clk) begin
      status_ff <= 1'b0;
   end
   assign status_wr = status_ff;

   // checks
   property p_fast_done;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src) |=> done;
   endproperty
   a_fast_done: assert property (p_fast_done) else $error("done not one cycle");

   property p_slow_done;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && req.periph_src) |=> !done ##1 done;
   endproperty
   a_slow_done: assert property (p_slow_done) else $error("periph stall wrong");

   property p_no_flags;
      @(posedge clk) disable iff (reset) done |-> !status_wr;
   endproperty
   a_no_flags: assert property (p_no_flags) else $error("status written");

   property p_pair;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_PAIR) |=>
         wb.wr_lo && wb.wr_hi && wb.hi_reg == wb.lo_reg + IMU_REG_STEP
         && wb.lo_reg == $past(req.dst_reg)
         && {wb.hi_data, wb.lo_data} == $past(prod);
   endproperty
   a_pair: assert property (p_pair) else $error("pair write wrong");

   property p_word;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_WORD) |=>
         wb.wr_lo && !wb.wr_hi && !wb.acc_wr;
   endproperty
   a_word: assert property (p_word) else $error("word write wrong");

   property p_uu;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_PAIR
         && !req.base_signed && !req.src_signed && !req.use_lit) |=>
         {wb.hi_data, wb.lo_data} == $past(base_operand_reg) * $past(source_operand_reg);
   endproperty
   a_uu: assert property (p_uu) else $error("unsigned product wrong");

   property p_acc;
      @(posedge clk) disable iff (reset)
      (done && wb.acc_wr) |-> wb.acc_data[IMU_AW-1:IMU_PW]
         == {(IMU_AW-IMU_PW){$past(prod_signed) & wb.acc_data[IMU_PW-1]}};
   endproperty
   a_acc: assert property (p_acc) else $error("acc extension wrong");

   property p_file;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_FILE) |=>
         wb.lo_reg == IMU_PROD_LO_REG && wb.hi_reg == IMU_PROD_HI_REG
         && {wb.hi_data, wb.lo_data} == $past(file_word) * $past(default_working_reg);
   endproperty
   a_file: assert property (p_file) else $error("file form wrong");

   // products checked against port operands, not the internal multiplier
   property p_ss;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_PAIR
         && req.base_signed && req.src_signed && !req.use_lit) |=>
         $signed({wb.hi_data, wb.lo_data})
         == $signed($past(base_operand_reg)) * $signed($past(source_operand_reg));
   endproperty
   a_ss: assert property (p_ss) else $error("signed product wrong");

   property p_su;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_PAIR
         && req.base_signed && !req.src_signed && !req.use_lit) |=>
         $signed({wb.hi_data, wb.lo_data})
         == $signed($past(base_operand_reg)) * $signed({1'b0, $past(source_operand_reg)});
   endproperty
   a_su: assert property (p_su) else $error("signed by unsigned wrong");

   property p_us;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_PAIR
         && !req.base_signed && req.src_signed && !req.use_lit) |=>
         $signed({wb.hi_data, wb.lo_data})
         == $signed({1'b0, $past(base_operand_reg)}) * $signed($past(source_operand_reg));
   endproperty
   a_us: assert property (p_us) else $error("unsigned by signed wrong");

   // low word is the same for every signedness form
   property p_word_data;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_WORD && !req.use_lit) |=>
         wb.lo_reg == $past(req.dst_reg)
         && wb.lo_data == $past(base_operand_reg) * $past(source_operand_reg);
   endproperty
   a_word_data: assert property (p_word_data) else $error("word data wrong");

   property p_acc_su;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_ACC
         && req.base_signed && !req.src_signed && !req.use_lit) |=>
         wb.acc_sel == $past(req.acc_sel) && $signed(wb.acc_data)
         == $signed($past(base_operand_reg)) * $signed({1'b0, $past(source_operand_reg)});
   endproperty
   a_acc_su: assert property (p_acc_su) else $error("acc mixed product wrong");

   property p_lit_acc;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_ACC
         && req.use_lit && !req.base_signed) |=>
         wb.acc_data == $past(base_operand_reg) * $past(req.lit);
   endproperty
   a_lit_acc: assert property (p_lit_acc) else $error("literal acc wrong");

   property p_lit_pair;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && !req.periph_src && req.dst == IMU_DST_PAIR
         && req.use_lit && !req.base_signed) |=>
         {wb.hi_data, wb.lo_data} == $past(base_operand_reg) * $past(req.lit);
   endproperty
   a_lit_pair: assert property (p_lit_pair) else $error("literal pair wrong");

   // write-back is quiet outside the done pulse
   property p_idle_zero;
      @(posedge clk) disable iff (reset) !done |-> wb == '0;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("stray write-back");

   property p_ready_stall;
      @(posedge clk) disable iff (reset)
      (req_valid && req_ready && req.periph_src) |=> !req_ready ##1 req_ready;
   endproperty
   a_ready_stall: assert property (p_ready_stall) else $error("stall ready wrong");

   c_acc: cover property (@(posedge clk) disable iff (reset) done && wb.acc_wr);
   c_stall: cover property (@(posedge clk) disable iff (reset) state_ff == IMU_ST_WAIT);
   c_file: cover property (@(posedge clk) disable iff (reset) done && wb.lo_reg == IMU_PROD_LO_REG);
   c_word: cover property (@(posedge clk) disable iff (reset) done && wb.wr_lo && !wb.wr_hi);
   c_lit: cover property (@(posedge clk) disable iff (reset) fire && cur.use_lit);
endmodule

`default_nettype wire

// ### logic/imu_pkg.sv
// Purpose: shared types and constants of the integer multiply unit
// Assumes: 16-bit data path, 40-bit accumulators, 16 working registers
// Notes: forms are decoded upstream into the request struct

package imu_pkg;
   localparam int IMU_DW = 16;
   localparam int IMU_PW = 32;
   localparam int IMU_AW = 40;
   localparam int IMU_RW = 4;
   localparam int IMU_LW = 5;
   localparam logic [IMU_RW-1:0] IMU_PROD_LO_REG = 4'h2;
   localparam logic [IMU_RW-1:0] IMU_PROD_HI_REG = 4'h3;
   localparam logic [IMU_RW-1:0] IMU_REG_STEP = 4'h1;
   localparam logic [1:0] IMU_LAT_BASE = 2'h1;
   localparam logic [1:0] IMU_LAT_PERIPH = 2'h1;

   typedef enum logic [1:0] {
      IMU_DST_PAIR,
      IMU_DST_WORD,
      IMU_DST_ACC,
      IMU_DST_FILE
   } imu_dst_e;

   typedef struct packed {
      logic base_signed;
      logic src_signed;
      logic use_lit;
      imu_dst_e dst;
      logic acc_sel;
      logic [IMU_RW-1:0] dst_reg;
      logic [IMU_LW-1:0] lit;
      logic periph_src;
   } imu_req_s;

   typedef struct packed {
      logic wr_lo;
      logic wr_hi;
      logic [IMU_RW-1:0] lo_reg;
      logic [IMU_RW-1:0] hi_reg;
      logic [IMU_DW-1:0] lo_data;
      logic [IMU_DW-1:0] hi_data;
      logic acc_wr;
      logic acc_sel;
      logic [IMU_AW-1:0] acc_data;
   } imu_wb_s;
endpackage

// ### logic/imu_mult_core.sv
// Purpose: 17x17 signed multiplier covering all signedness forms
// Assumes: operands are 16 bits wide
// Notes: each operand gets a sign bit chosen by its mode flag

`timescale 1ns/1ns
`default_nettype none

module imu_mult_core
   import imu_pkg::*;
(
   input wire logic [IMU_DW-1:0] a,
   input wire logic a_signed,
   input wire logic [IMU_DW-1:0] b,
   input wire logic b_signed,
   output logic [IMU_PW-1:0] prod,
   output logic prod_signed
);
   logic signed [IMU_DW:0] a_ext;
   logic signed [IMU_DW:0] b_ext;
   logic signed [2*IMU_DW+1:0] full;

   // one extra bit per side lets one signed multiplier serve every form
   always_comb begin
      a_ext = {a_signed & a[IMU_DW-1], a};
      b_ext = {b_signed & b[IMU_DW-1], b};
      full = (2*IMU_DW+2)'(a_ext) * (2*IMU_DW+2)'(b_ext);
      prod = full[IMU_PW-1:0];
      prod_signed = a_signed | b_signed;
   end
endmodule

`default_nettype wire

// ### logic/imu_acc_extend.sv
// Purpose: widen a 32-bit product to accumulator width
// Assumes: accumulator is wider than the product
// Notes: sign or zero fill per result signedness

`timescale 1ns/1ns
`default_nettype none

module imu_acc_extend
   import imu_pkg::*;
(
   input wire logic [IMU_PW-1:0] prod,
   input wire logic prod_signed,
   output logic [IMU_AW-1:0] acc_val
);
   always_comb begin
      acc_val = {{(IMU_AW-IMU_PW){prod_signed & prod[IMU_PW-1]}}, prod};
   end
endmodule

`default_nettype wire

// ### verif/imu_top_tb_top.sv
// Purpose: self-checking bench for the integer multiply unit
// Assumes: one done pulse per taken request, results in issue order
// Notes: driver queues expectations, watcher pops them on done
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end

module imu_top_tb_top
   import imu_pkg::*;
;
   typedef struct {imu_wb_s w; int due;} imu_exp_s;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   imu_req_s req = '0;
   logic [IMU_DW-1:0] base_operand_reg = '0;
   logic [IMU_DW-1:0] source_operand_reg = '0;
   logic [IMU_DW-1:0] file_word = '0;
   logic [IMU_DW-1:0] default_working_reg = '0;
   logic req_ready;
   logic done;
   logic status_wr;
   imu_wb_s wb;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int stall_cyc = -1;
   logic [31:0] rng = 32'h000150EC;
   imu_exp_s exp_q[$];
   imu_exp_s got_e;

   imu_top imu_top_inst (
      .clk(clk),
      .reset(reset),
      .req_valid(req_valid),
      .req(req),
      .base_operand_reg(base_operand_reg),
      .source_operand_reg(source_operand_reg),
      .file_word(file_word),
      .default_working_reg(default_working_reg),
      .req_ready(req_ready),
      .done(done),
      .wb(wb),
      .status_wr(status_wr)
   );

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
   end

   function automatic logic [31:0] nxt();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // watcher: results must arrive in order and on the promised cycle
   always @(negedge clk) begin
      if (reset === 1'b0) begin
         `CHK(status_wr, 1'b0)
         `CHK(req_ready, (cyc != stall_cyc))
         if (done === 1'b1) begin
            `CHK(exp_q.size() > 0, 1'b1)
            if (exp_q.size() > 0) begin
               got_e = exp_q.pop_front();
               `CHK(cyc, got_e.due)
               `CHK(wb.acc_wr, got_e.w.acc_wr)
               `CHK(wb.wr_lo, got_e.w.wr_lo)
               `CHK(wb.wr_hi, got_e.w.wr_hi)
               if (got_e.w.acc_wr) begin
                  `CHK(wb.acc_sel, got_e.w.acc_sel)
                  `CHK(wb.acc_data, got_e.w.acc_data)
               end
               if (got_e.w.wr_lo) begin
                  `CHK(wb.lo_reg, got_e.w.lo_reg)
                  `CHK(wb.lo_data, got_e.w.lo_data)
               end
               if (got_e.w.wr_hi) begin
                  `CHK(wb.hi_reg, got_e.w.hi_reg)
                  `CHK(wb.hi_data, got_e.w.hi_data)
               end
            end
         end else begin
            `CHK(wb, '0)
         end
      end
   end

   // requests offered during a stall are random and must be ignored
   task automatic issue(input int i);
      imu_exp_s e;
      imu_req_s r;
      logic signed [33:0] p;
      logic as;
      logic bs;
      logic [IMU_DW-1:0] a;
      logic [IMU_DW-1:0] b;
      logic [31:0] x;
      int n;
      n = 0;
      while (req_ready !== 1'b1) begin
         req_valid = 1'b1;
         x = nxt();
         req = imu_req_s'(x[$bits(imu_req_s)-1:0]);
         n++;
         if (n > 20) begin
            bad_count++;
            print_verdict();
         end
         @(negedge clk);
      end
      x = nxt();
      r = '0;
      r.dst = imu_dst_e'(i % 4);
      r.base_signed = i[2];
      r.src_signed = i[3];
      r.use_lit = i[4] && (r.dst != IMU_DST_FILE);
      r.acc_sel = x[0];
      r.dst_reg = x[4:1];
      r.lit = x[9:5];
      r.periph_src = (i % 7 == 3);
      a = x[31:16];
      b = IMU_DW'(nxt());
      if (i % 5 == 1) begin
         a = 16'h8000;
         b = 16'hFFFF;
      end
      base_operand_reg = a;
      source_operand_reg = b;
      file_word = IMU_DW'(nxt());
      default_working_reg = IMU_DW'(nxt());
      as = r.base_signed;
      bs = r.src_signed && !r.use_lit;
      if (r.use_lit) begin
         b = {11'h000, r.lit};
      end
      if (r.dst == IMU_DST_FILE) begin
         a = file_word;
         b = default_working_reg;
         as = 1'b0;
         bs = 1'b0;
      end
      p = $signed({as & a[15], a}) * $signed({bs & b[15], b});
      e.w = '0;
      e.due = cyc + IMU_LAT_BASE + (r.periph_src ? IMU_LAT_PERIPH : 2'h0);
      if (r.dst == IMU_DST_ACC) begin
         e.w.acc_wr = 1'b1;
         e.w.acc_sel = r.acc_sel;
         e.w.acc_data = (as | bs) ? {{8{p[31]}}, p[31:0]} : {8'h00, p[31:0]};
      end else begin
         e.w.wr_lo = 1'b1;
         e.w.wr_hi = (r.dst != IMU_DST_WORD);
         e.w.lo_data = p[15:0];
         e.w.hi_data = p[31:16];
         e.w.lo_reg = (r.dst == IMU_DST_FILE) ? IMU_PROD_LO_REG : r.dst_reg;
         e.w.hi_reg = (r.dst == IMU_DST_FILE) ? IMU_PROD_HI_REG : r.dst_reg + IMU_REG_STEP;
      end
      req = r;
      req_valid = 1'b1;
      if (r.periph_src) begin
         stall_cyc = cyc + IMU_LAT_BASE;
      end
      exp_q.push_back(e);
      @(negedge clk);
   endtask

   initial begin
      int n;
      repeat (2) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      for (int i = 0; i < 400; i++) begin
         issue(i);
         if (i % 9 == 8) begin
            req_valid = 1'b0;
            @(negedge clk);
         end
      end
      req_valid = 1'b0;
      n = 0;
      while (exp_q.size() > 0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (exp_q.size() > 0) begin
         bad_count++;
      end
      print_verdict();
   end
endmodule
`default_nettype wire
